// ==== core/block_ram.sv ====
// Dual-port block memory: two port lanes, shared storage array and queue address generator
`timescale 1ns/1ps
module ram_port_lane (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, low active
  input wire logic port_clock, // Active-edge enable pulse
  input wire logic select_n, // Port enable, low active
  input wire logic write_low, // Low write, high read
  input wire logic [1:0] shape_sel, // Organisation
  input wire logic output_register_sel, // Extra output stage
  input wire logic write_echo_sel, // Pass write data to output
  input wire logic [11:0] word_index, // Narrow-word address
  input wire logic [8:0] write_data, // Write data, low bits used
  input wire logic [8:0] stored_word, // Array row at row_index
  output logic [8:0] row_index, // Array row addressed
  output logic [8:0] row_mask, // Bits of the row written
  output logic [8:0] row_bits, // Write data placed in the row
  output logic row_write, // Write strobe this cycle
  output logic [8:0] read_data // Port output, from flops
);
  logic [8:0] stage;
  logic [8:0] next_stage;
  logic [8:0] next_read_data;
  logic [1:0] sub_shift;
  logic [3:0] lane_pos;
  logic [8:0] low_mask;
  logic [8:0] fetched;
  logic active;

  // Address split: row from the high bits, lane position from the low ones
  always_comb begin
    sub_shift = ram_pkg::SHAPE_MAX_SHIFT - shape_sel;
    row_index = 9'(word_index >> sub_shift);
    lane_pos = 4'((word_index & ((12'h001 << sub_shift) - 12'h001)) << shape_sel);
    // Narrow lanes stop at bit 7, so the ninth bit is out of reach
    low_mask = (shape_sel == ram_pkg::SHAPE_512X9) ? ram_pkg::FULL_WORD_MASK :
               9'((9'h001 << (4'h1 << shape_sel)) - 9'h001);
    row_mask = 9'(low_mask << lane_pos);
    row_bits = 9'((write_data & low_mask) << lane_pos);
    // Bits above the width read as zero, one legal value of undefined
    fetched = 9'(stored_word >> lane_pos) & low_mask;
    active = port_clock & ~select_n & hresetn;
    row_write = active & ~write_low;
  end

  // Output hold, echo and optional pipeline stage
  always_comb begin
    next_stage = stage;
    next_read_data = read_data;
    if (active) begin
      if (write_low) begin
        next_stage = fetched;
      end else if (write_echo_sel) begin
        next_stage = write_data & low_mask;
      end
      next_read_data = output_register_sel ? stage : next_stage;
    end
  end

  // Only the hold registers clear; the array is not touched here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage <= '0;
      read_data <= '0;
    end else begin
      stage <= next_stage;
      read_data <= next_read_data;
    end
  end
endmodule : ram_port_lane

module block_ram (
  input wire logic hclk, // System clock, 50 MHz
  input wire logic hresetn, // Asynchronous reset, low active
  ram_link_if.mem link // Both memory ports
);
  logic [8:0] store [0:ram_pkg::ROWS-1];
  logic [8:0] row_a, row_b, mask_a, mask_b, bits_a, bits_b;
  logic write_a, write_b;
  logic [11:0] index_a, index_b;
  logic [11:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [12:0] fill, next_fill, span;
  logic q_push, q_pop;

  // Queue span follows the port A organisation, both ports assumed alike
  always_comb begin
    span = ram_pkg::QUEUE_SPAN >> link.port_a_shape_sel;
    q_push = link.queue_mode & write_a & (fill != span);
    q_pop = link.queue_mode & link.port_b_clock & ~link.port_b_select_n & link.port_b_write_low
            & hresetn & (fill != '0);
    // User addresses in RAM mode, queue pointers otherwise
    index_a = link.queue_mode ? wr_ptr : link.port_a_word_index;
    index_b = link.queue_mode ? rd_ptr : link.port_b_word_index;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill = fill;
    if (q_push) begin
      next_wr_ptr = (13'(wr_ptr) + 13'h0001 == span) ? '0 : wr_ptr + 12'h001;
    end
    if (q_pop) begin
      next_rd_ptr = (13'(rd_ptr) + 13'h0001 == span) ? '0 : rd_ptr + 12'h001;
    end
    if (q_push && !q_pop) begin
      next_fill = fill + 13'h0001;
    end else if (q_pop && !q_push) begin
      next_fill = fill - 13'h0001;
    end
  end

  // Queue pointers clear with the control logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill <= next_fill;
    end
  end

  assign link.full_flag = (fill == span);
  assign link.empty_flag = (fill == '0);
  assign link.almost_full_flag = (fill >= span - ram_pkg::QUEUE_ALMOST_LEVEL);
  assign link.almost_empty_flag = (fill <= ram_pkg::QUEUE_ALMOST_LEVEL);

  // Each port has its own enable pulse, so rates are free per port
  ram_port_lane lane_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .port_clock(link.port_a_clock),
    .select_n(link.port_a_select_n),
    .write_low(link.port_a_write_low),
    .shape_sel(link.port_a_shape_sel),
    .output_register_sel(link.port_a_output_register_sel),
    .write_echo_sel(link.port_a_write_echo_sel),
    .word_index(index_a),
    .write_data(link.port_a_write_data),
    .stored_word(store[row_a]),
    .row_index(row_a),
    .row_mask(mask_a),
    .row_bits(bits_a),
    .row_write(write_a),
    .read_data(link.port_a_read_data)
  );

  ram_port_lane lane_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .port_clock(link.port_b_clock),
    .select_n(link.port_b_select_n),
    .write_low(link.port_b_write_low),
    .shape_sel(link.port_b_shape_sel),
    .output_register_sel(link.port_b_output_register_sel),
    .write_echo_sel(link.port_b_write_echo_sel),
    .word_index(index_b),
    .write_data(link.port_b_write_data),
    .stored_word(store[row_b]),
    .row_index(row_b),
    .row_mask(mask_b),
    .row_bits(bits_b),
    .row_write(write_b),
    .read_data(link.port_b_read_data)
  );

  // Bitwise writes let both ports update distinct lanes of one row at once
  // Same bit from both ports: port B wins, the result is not promised
  always_ff @(posedge hclk) begin
    for (int b = 0; b < ram_pkg::DATA_BITS; b++) begin
      if (write_a && mask_a[b]) begin
        store[row_a][b] <= bits_a[b];
      end
      if (write_b && mask_b[b]) begin
        store[row_b][b] <= bits_b[b];
      end
    end
  end
endmodule : block_ram

// ==== core/ram_pkg.sv ====
// Shared constants for the dual-port block memory and its controlling user logic
// Overview of operation
// - Reads and writes only on port clock edges
// - Port clocks independent, each up to 350 MHz
// - Port clocks separate or common driver
// - Two reads, two writes, or read plus write
// - RAM mode takes addresses from user logic
// - Queue mode: internal addresses, four occupancy flags
// - Write and read widths set independently
// - Shape 00/01/10/11 gives 4kx1/2kx2/1kx4/512x9
// - User logic holds shape selects constant
// - Narrow widths never reach the ninth bit
// - Nine-bit read of nibble data: ninth undefined
// - Narrow words packed little-endian in wide words
// - Select low enables; high holds port output
// - Write control low writes, high reads
// - Output register: off same cycle, on one later
// - Write echo passes write data; ignored on reads
// - Reset clears outputs, keeps array contents
// - No reads or writes during reset
// - User logic moves reset away from clock edges
// - User logic zeroes unused high address bits
// - User logic zeroes unused high write bits
// - Read data above width is undefined
package ram_pkg;
  localparam int unsigned CLOCK_HZ = 50_000_000;
  localparam int unsigned PORT_CLOCK_MAX_MHZ = 350;
  localparam int unsigned DATA_BITS = 9;
  localparam int unsigned INDEX_BITS = 12;
  localparam int unsigned ROWS = 512;
  localparam int unsigned ROW_BITS = 9;
  localparam int unsigned COUNT_BITS = 13;
  // Shape select codes
  localparam logic [1:0] SHAPE_4KX1 = 2'h0;
  localparam logic [1:0] SHAPE_2KX2 = 2'h1;
  localparam logic [1:0] SHAPE_1KX4 = 2'h2;
  localparam logic [1:0] SHAPE_512X9 = 2'h3;
  localparam logic [1:0] SHAPE_MAX_SHIFT = 2'h3;
  localparam logic [8:0] FULL_WORD_MASK = 9'h1ff;
  localparam logic [12:0] QUEUE_SPAN = 13'h1000;
  localparam logic [12:0] QUEUE_ALMOST_LEVEL = 13'h0004;
  // Controller register map (byte addresses)
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_PORT_A_CMD = 4'h4;
  localparam logic [3:0] REG_PORT_B_CMD = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  // Config fields
  localparam int unsigned CFG_SHAPE_A_LSB = 0;
  localparam int unsigned CFG_SHAPE_B_LSB = 2;
  localparam int unsigned CFG_OUT_REG_A = 4;
  localparam int unsigned CFG_OUT_REG_B = 5;
  localparam int unsigned CFG_ECHO_A = 6;
  localparam int unsigned CFG_ECHO_B = 7;
  localparam int unsigned CFG_QUEUE = 8;
  localparam int unsigned CFG_BITS = 9;
  localparam logic [8:0] CFG_RESET = 9'h000;
  // Command fields
  localparam int unsigned CMD_INDEX_LSB = 0;
  localparam int unsigned CMD_DATA_LSB = 12;
  localparam int unsigned CMD_READ = 21;
  // Status fields
  localparam int unsigned ST_DATA_A_LSB = 0;
  localparam int unsigned ST_DATA_B_LSB = 9;
  localparam int unsigned ST_FULL = 18;
  localparam int unsigned ST_EMPTY = 19;
  localparam int unsigned ST_ALMOST_FULL = 20;
  localparam int unsigned ST_ALMOST_EMPTY = 21;
endpackage : ram_pkg

// ==== core/ram_link_if.sv ====
// Connection between the memory block and the user logic that drives both ports
`timescale 1ns/1ps
interface ram_link_if;
  logic port_a_clock; // Port A active-edge enable pulse
  logic port_b_clock; // Port B active-edge enable pulse
  logic port_a_select_n; // Port A enable, low active
  logic port_b_select_n; // Port B enable, low active
  logic port_a_write_low; // Port A low write, high read
  logic port_b_write_low; // Port B low write, high read
  logic [1:0] port_a_shape_sel; // Port A organisation
  logic [1:0] port_b_shape_sel; // Port B organisation
  logic port_a_output_register_sel; // Port A extra output stage
  logic port_b_output_register_sel; // Port B extra output stage
  logic port_a_write_echo_sel; // Port A write pass-through
  logic port_b_write_echo_sel; // Port B write pass-through
  logic [11:0] port_a_word_index; // Port A address
  logic [11:0] port_b_word_index; // Port B address
  logic [8:0] port_a_write_data; // Port A write data
  logic [8:0] port_b_write_data; // Port B write data
  logic [8:0] port_a_read_data; // Port A read data
  logic [8:0] port_b_read_data; // Port B read data
  logic queue_mode; // High: internal queue addressing
  logic full_flag; // Queue full
  logic empty_flag; // Queue empty
  logic almost_full_flag; // Queue nearly full
  logic almost_empty_flag; // Queue nearly empty
  modport mem (
    input port_a_clock, port_b_clock, port_a_select_n, port_b_select_n,
    input port_a_write_low, port_b_write_low, port_a_shape_sel, port_b_shape_sel,
    input port_a_output_register_sel, port_b_output_register_sel,
    input port_a_write_echo_sel, port_b_write_echo_sel,
    input port_a_word_index, port_b_word_index, port_a_write_data, port_b_write_data, queue_mode,
    output port_a_read_data, port_b_read_data, full_flag, empty_flag, almost_full_flag, almost_empty_flag
  );
  modport user (
    output port_a_clock, port_b_clock, port_a_select_n, port_b_select_n,
    output port_a_write_low, port_b_write_low, port_a_shape_sel, port_b_shape_sel,
    output port_a_output_register_sel, port_b_output_register_sel,
    output port_a_write_echo_sel, port_b_write_echo_sel,
    output port_a_word_index, port_b_word_index, port_a_write_data, port_b_write_data, queue_mode,
    input port_a_read_data, port_b_read_data, full_flag, empty_flag, almost_full_flag, almost_empty_flag
  );
endinterface : ram_link_if

// ==== core/ram_user_ctrl.sv ====
// User logic driving both memory ports, ordered by software over AHB-Lite
`timescale 1ns/1ps
module ram_user_ctrl (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, low active
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Always ready
  output logic [31:0] hrdata, // Read data, registered
  output logic hresp, // Always OKAY
  ram_link_if.user link // Memory ports
);
  logic [3:0] data_addr, next_data_addr;
  logic data_write, next_data_write;
  logic [8:0] cfg, next_cfg;
  logic [31:0] next_hrdata;
  logic [21:0] cmd_a, next_cmd_a, cmd_b, next_cmd_b;
  logic go_a, next_go_a, go_b, next_go_b;

  // Zero wait states; the single slave never errors
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address decode and register updates
  always_comb begin
    next_data_addr = data_addr;
    next_data_write = 1'b0;
    next_cfg = cfg;
    next_cmd_a = cmd_a;
    next_cmd_b = cmd_b;
    next_go_a = 1'b0;
    next_go_b = 1'b0;
    next_hrdata = hrdata;
    if (data_write) begin
      case (data_addr)
        ram_pkg::REG_CONFIG: next_cfg = hwdata[ram_pkg::CFG_BITS-1:0];
        ram_pkg::REG_PORT_A_CMD: begin
          next_cmd_a = hwdata[21:0];
          next_go_a = 1'b1;
        end
        ram_pkg::REG_PORT_B_CMD: begin
          next_cmd_b = hwdata[21:0];
          next_go_b = 1'b1;
        end
        default: next_cfg = cfg;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      next_data_addr = haddr[3:0];
      next_data_write = hwrite;
      next_hrdata = '0;
      if (!hwrite) begin
        case (haddr[3:0])
          ram_pkg::REG_CONFIG: next_hrdata = 32'(cfg);
          ram_pkg::REG_PORT_A_CMD: next_hrdata = 32'(cmd_a);
          ram_pkg::REG_PORT_B_CMD: next_hrdata = 32'(cmd_b);
          ram_pkg::REG_STATUS: begin
            next_hrdata[ram_pkg::ST_DATA_A_LSB +: 9] = link.port_a_read_data;
            next_hrdata[ram_pkg::ST_DATA_B_LSB +: 9] = link.port_b_read_data;
            next_hrdata[ram_pkg::ST_FULL] = link.full_flag;
            next_hrdata[ram_pkg::ST_EMPTY] = link.empty_flag;
            next_hrdata[ram_pkg::ST_ALMOST_FULL] = link.almost_full_flag;
            next_hrdata[ram_pkg::ST_ALMOST_EMPTY] = link.almost_empty_flag;
          end
          default: next_hrdata = '0;
        endcase
      end
    end
  end

  // No port pulse can leave while reset holds these low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_addr <= '0;
      data_write <= 1'b0;
      cfg <= ram_pkg::CFG_RESET;
      cmd_a <= '0;
      cmd_b <= '0;
      go_a <= 1'b0;
      go_b <= 1'b0;
      hrdata <= '0;
    end else begin
      data_addr <= next_data_addr;
      data_write <= next_data_write;
      cfg <= next_cfg;
      cmd_a <= next_cmd_a;
      cmd_b <= next_cmd_b;
      go_a <= next_go_a;
      go_b <= next_go_b;
      hrdata <= next_hrdata;
    end
  end

  // Both port pulses share hclk, the common-driver case
  assign link.port_a_clock = go_a;
  assign link.port_b_clock = go_b;
  assign link.port_a_select_n = ~go_a;
  assign link.port_b_select_n = ~go_b;
  assign link.port_a_write_low = cmd_a[ram_pkg::CMD_READ];
  assign link.port_b_write_low = cmd_b[ram_pkg::CMD_READ];
  assign link.port_a_shape_sel = cfg[ram_pkg::CFG_SHAPE_A_LSB +: 2];
  assign link.port_b_shape_sel = cfg[ram_pkg::CFG_SHAPE_B_LSB +: 2];
  assign link.port_a_output_register_sel = cfg[ram_pkg::CFG_OUT_REG_A];
  assign link.port_b_output_register_sel = cfg[ram_pkg::CFG_OUT_REG_B];
  assign link.port_a_write_echo_sel = cfg[ram_pkg::CFG_ECHO_A];
  assign link.port_b_write_echo_sel = cfg[ram_pkg::CFG_ECHO_B];
  assign link.queue_mode = cfg[ram_pkg::CFG_QUEUE];
  // Unused high bits are forced to zero for the chosen shape
  assign link.port_a_word_index = cmd_a[11:0] & (12'hfff >> cfg[ram_pkg::CFG_SHAPE_A_LSB +: 2]);
  assign link.port_b_word_index = cmd_b[11:0] & (12'hfff >> cfg[ram_pkg::CFG_SHAPE_B_LSB +: 2]);
  assign link.port_a_write_data = cmd_a[ram_pkg::CMD_DATA_LSB +: 9] & width_mask(link.port_a_shape_sel);
  assign link.port_b_write_data = cmd_b[ram_pkg::CMD_DATA_LSB +: 9] & width_mask(link.port_b_shape_sel);
  // Commands come from separate bus beats, so two writes never meet in one cycle

  function automatic logic [8:0] width_mask(input logic [1:0] shape);
    width_mask = (shape == ram_pkg::SHAPE_512X9) ? ram_pkg::FULL_WORD_MASK :
                 9'((9'h001 << (4'h1 << shape)) - 9'h001);
  endfunction : width_mask
endmodule : ram_user_ctrl

// ==== verif/ram_link_props.sv ====
// Concurrent checks on the link between the user logic and the memory block
`timescale 1ns/1ps
module ram_link_props (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Reset, low active
  input wire logic port_a_clock, // A edge pulse
  input wire logic port_b_clock, // B edge pulse
  input wire logic port_a_select_n, // A enable, low active
  input wire logic port_b_select_n, // B enable, low active
  input wire logic port_a_write_low, // A write when low
  input wire logic [1:0] port_a_shape_sel, // A organisation
  input wire logic port_a_output_register_sel, // A output stage
  input wire logic port_a_write_echo_sel, // A write echo
  input wire logic [11:0] port_a_word_index, // A address
  input wire logic [8:0] port_a_write_data, // A write data
  input wire logic [8:0] port_a_read_data, // A read data
  input wire logic [8:0] port_b_read_data, // B read data
  input wire logic full_flag, // Queue full
  input wire logic empty_flag, // Queue empty
  input wire logic almost_full_flag, // Queue nearly full
  input wire logic almost_empty_flag // Queue nearly empty
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Active edges of each port
  wire a_edge = port_a_clock && !port_a_select_n;
  wire b_edge = port_b_clock && !port_b_select_n;
  // Write on A without the extra output stage, so its effect shows one edge later
  sequence a_plain_write;
    a_edge && !port_a_write_low && !port_a_output_register_sel;
  endsequence
  sequence a_narrow_read;
    a_edge && port_a_write_low && !port_a_output_register_sel && port_a_shape_sel == 2'h0;
  endsequence
  AST_RESET_CLEARS: assert property ($rose(hresetn) |-> port_a_read_data == 9'h0 && port_b_read_data == 9'h0)
    else $error("read data not cleared by reset");
  AST_RESET_IDLE: assert property ($rose(hresetn) |-> !port_a_clock && !port_b_clock && empty_flag)
    else $error("port activity during reset");
  AST_A_HOLD: assert property (!a_edge |=> $stable(port_a_read_data))
    else $error("port A output moved without an active edge");
  AST_B_HOLD: assert property (!b_edge |=> $stable(port_b_read_data))
    else $error("port B output moved without an active edge");
  AST_ECHO_ON: assert property (a_plain_write ##0 port_a_write_echo_sel && port_a_shape_sel == 2'h3
    |=> port_a_read_data == $past(port_a_write_data)) else $error("write data not echoed");
  AST_ECHO_OFF: assert property (a_plain_write ##0 !port_a_write_echo_sel |=> $stable(port_a_read_data))
    else $error("write without echo changed the output");
  AST_NARROW_TOP: assert property (a_narrow_read |=> port_a_read_data[8:1] == 8'h0)
    else $error("one-bit read reached upper bits");
  AST_INDEX_ZERO: assert property (port_a_clock && port_a_shape_sel == 2'h3 |-> port_a_word_index[11:9] == 3'h0)
    else $error("unused address bits not zero");
  AST_DATA_ZERO: assert property (port_a_clock && port_a_shape_sel == 2'h0 |-> port_a_write_data[8:1] == 8'h0)
    else $error("unused write bits not zero");
  AST_EMPTY_FLAGS: assert property (empty_flag |-> almost_empty_flag && !full_flag && !almost_full_flag)
    else $error("empty flag inconsistent");
  AST_FULL_FLAGS: assert property (full_flag |-> almost_full_flag && !almost_empty_flag)
    else $error("full flag inconsistent");
endmodule : ram_link_props

// ==== verif/dual_port_block_ram_tb.sv ====
// Self-checking bench: software orders over AHB-Lite reach the memory through the user logic
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module dual_port_block_ram_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  int n_errors = 0;
  int compares = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] rd_val;
  logic [31:0] m_got;
  logic [31:0] m_exp;
  logic [16:0] lf = 17'h12d0b;
  event rd_ev;
  ram_link_if link ();
  // Clock and the single slave's ready fed back as the bus ready
  always #10 hclk = ~hclk;
  assign hready = hreadyout;
  ram_user_ctrl i_ram_user_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .link(link.user));
  block_ram i_block_ram (.hclk(hclk), .hresetn(hresetn), .link(link.mem));
  ram_link_props i_ram_link_props (.hclk(hclk), .hresetn(hresetn), .port_a_clock(link.port_a_clock),
    .port_b_clock(link.port_b_clock), .port_a_select_n(link.port_a_select_n), .port_b_select_n(link.port_b_select_n),
    .port_a_write_low(link.port_a_write_low), .port_a_shape_sel(link.port_a_shape_sel),
    .port_a_output_register_sel(link.port_a_output_register_sel), .port_a_write_echo_sel(link.port_a_write_echo_sel),
    .port_a_word_index(link.port_a_word_index), .port_a_write_data(link.port_a_write_data),
    .port_a_read_data(link.port_a_read_data), .port_b_read_data(link.port_b_read_data), .full_flag(link.full_flag),
    .empty_flag(link.empty_flag), .almost_full_flag(link.almost_full_flag), .almost_empty_flag(link.almost_empty_flag));
  // Random source: 17-bit shift register with feedback
  function automatic logic [16:0] step(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : step
  // Expected queue flags for a fill count, span 512
  function automatic logic [31:0] flags(input int c);
    return {10'h0, c <= 4, c >= 508, c == 0, c == 512, 18'h0};
  endfunction : flags
  // One single-word transfer; both phases wait for ready, read data taken at the data-phase edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {28'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : bus
  task automatic cfg(input logic [1:0] sa, input logic [1:0] sb, input logic oa, input logic ea, input logic qm);
    logic [31:0] r;
    bus(1'b1, ram_pkg::REG_CONFIG, {23'h0, qm, 1'b0, ea, 1'b0, oa, sb, sa}, r);
  endtask : cfg
  // Port command; the pulse lands in the cycle right after the data phase, so wait before looking
  task automatic cmd(input logic pb, input logic [11:0] idx, input logic [8:0] d, input logic rd);
    logic [31:0] r;
    bus(1'b1, pb ? ram_pkg::REG_PORT_B_CMD : ram_pkg::REG_PORT_A_CMD, {10'h0, rd, d, idx}, r);
    repeat (2) @(posedge hclk);
  endtask : cmd
  // Note the expectation, then read status for the monitor
  task automatic chk(input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, ram_pkg::REG_STATUS, 32'h0, r);
    rd_val = r;
    -> rd_ev;
  endtask : chk
  task automatic give_verdict();
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // Monitor pairs each status read with the oldest expectation
  initial forever begin
    @(rd_ev);
    m_got = rd_val & msk_q.pop_front();
    m_exp = exp_q.pop_front();
    `CHK(m_got, m_exp)
  end
  // Watchdog well beyond the roughly 2.2k cycles the sequence needs
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    give_verdict();
  end
  initial begin
    logic [8:0] d, e, f, first;
    logic [11:0] x, y;
    int w;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(32'h0028_0000, 32'h003f_ffff);
    // B writes a whole row, A reads one lane of it in every shape (the whole word at 512x9), B reads the row back
    for (int s = 0; s < 4; s++) begin
      cfg(s[1:0], 2'h3, 1'b0, 1'b0, 1'b0);
      lf = step(lf);
      d = lf[8:0];
      w = 1 << s;
      x = 12'((int'(lf[16:8]) << (3 - s)) + int'(lf[2:0] >> s));
      e = (s == 3) ? d : 9'((int'(d) >> (int'(lf[2:0] >> s) * w)) % (1 << w));
      cmd(1'b1, {3'h0, lf[16:8]}, d, 1'b0);
      cmd(1'b0, x, 9'h0, 1'b1);
      cmd(1'b1, {3'h0, lf[16:8]}, 9'h0, 1'b1);
      chk({14'h0, d, e}, 32'h3ffff);
    end
    // Two nibbles written by A, read as one wide word by B; the ninth bit is not compared
    cfg(2'h2, 2'h3, 1'b0, 1'b0, 1'b0);
    lf = step(lf);
    cmd(1'b0, {2'h0, lf[16:8], 1'b0}, {5'h0, lf[3:0]}, 1'b0);
    cmd(1'b0, {2'h0, lf[16:8], 1'b1}, {5'h0, lf[7:4]}, 1'b0);
    cmd(1'b1, {3'h0, lf[16:8]}, 9'h0, 1'b1);
    chk({15'h0, lf[7:4], lf[3:0], 9'h0}, 32'h1fe00);
    // Write echo on, then off, then a read
    cfg(2'h3, 2'h3, 1'b0, 1'b1, 1'b0);
    lf = step(lf);
    e = lf[8:0];
    x = {3'h0, lf[16:8]};
    cmd(1'b0, x, e, 1'b0);
    chk({23'h0, e}, 32'h1ff);
    cfg(2'h3, 2'h3, 1'b0, 1'b0, 1'b0);
    cmd(1'b0, x, ~e, 1'b0);
    chk({23'h0, e}, 32'h1ff);
    cmd(1'b0, x, 9'h0, 1'b1);
    chk({23'h0, ~e}, 32'h1ff);
    // Output stage: each read shows the word of the previous active edge
    lf = step(lf);
    f = lf[8:0];
    y = x ^ 12'h1;
    cmd(1'b1, y, f, 1'b0);
    cfg(2'h3, 2'h3, 1'b1, 1'b0, 1'b0);
    cmd(1'b0, x, 9'h0, 1'b1);
    cmd(1'b0, y, 9'h0, 1'b1);
    chk({23'h0, ~e}, 32'h1ff);
    cmd(1'b0, y, 9'h0, 1'b1);
    chk({23'h0, f}, 32'h1ff);
    // Reset in mid-run clears outputs but keeps the array
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(32'h0028_0000, 32'h003f_ffff);
    cfg(2'h3, 2'h3, 1'b0, 1'b0, 1'b0);
    cmd(1'b1, y, 9'h0, 1'b1);
    chk({14'h0, f, 9'h0}, 32'h3fe00);
    // Queue mode: fill to full watching the flag edges, then pop the oldest word
    cfg(2'h3, 2'h3, 1'b0, 1'b0, 1'b1);
    for (int i = 1; i <= 512; i++) begin
      lf = step(lf);
      if (i == 1) first = lf[8:0];
      cmd(1'b0, 12'h0, lf[8:0], 1'b0);
      if (i == 4 || i == 5 || i == 507 || i == 508 || i == 512) chk(flags(i), 32'h3c0000);
    end
    cmd(1'b1, 12'h0, 9'h0, 1'b1);
    chk(flags(511) | {14'h0, first, 9'h0}, 32'h3ffe00);
    // Let the monitor take the last status read before the verdict
    @(posedge hclk);
    give_verdict();
  end
endmodule : dual_port_block_ram_tb
